// File: rtl/lpm_pkg.sv
// package: constants and types for the low-power mode controller
`default_nettype none
package lpm_pkg;
	localparam int N_START = 13;
	localparam int WAKE_MIN_NS = 50;
	localparam int CLK_NS = 100;
	localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
	// register byte addresses
	localparam logic [11:0] A_MODE = 12'h000;
	localparam logic [11:0] A_ENABLE = 12'h004;
	localparam logic [11:0] A_STATUS = 12'h008;
	localparam logic [11:0] A_START_FLAG = 12'h00c;
	// mode field encodings
	localparam logic [1:0] SEL_SLEEP = 2'h0;
	localparam logic [1:0] SEL_DEEP = 2'h1;
	localparam logic [1:0] SEL_DPD = 2'h2;
	localparam logic [1:0] MODE_RST = 2'h0;
	// option bit positions in mode register
	localparam int B_KEEP_WDOSC = 4;
	localparam int B_KEEP_BROWNOUT = 5;
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SLEEP,
		ST_DEEP,
		ST_DPD
	} pwr_state_t;
	typedef struct packed {
		logic core_clk_en;
		logic analog_en;
		logic wdosc_en;
		logic brownout_en;
		logic chip_power_en;
	} pwr_ctl_t;
endpackage
`default_nettype wire

// File: rtl/low_power_mode_control.sv
// low-power mode controller: sleep, deep-sleep, deep power-down
//
// Overview of operation
// - sleep gates only the core clock
// - exit sleep just re-enables core clock
// - sleep holds until reset or interrupt
// - peripherals run; their interrupts wake core
// - deep-sleep also powers down analog blocks
// - optional watchdog oscillator and brownout keep-alive
// - thirteen start pins wake from deep-sleep
// - deep power-down cuts all but wake pin
// - wake pin low at a rising pclk edge exits power-down; a 50 ns pulse between edges is missed
// - reset ignored in power-down; wake pin resets
// - each start pin drives its own interrupt
// - start pin wake still needs pclk edges to take effect
`default_nettype none
module low_power_mode_control #(
	parameter int N_START = lpm_pkg::N_START
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_req,
	input wire logic periph_irq,
	input wire logic [N_START-1:0] start_pin,
	input wire logic wake_pin_n,
	output logic [N_START-1:0] start_irq,
	output lpm_pkg::pwr_ctl_t pwr_ctl,
	output logic core_reset_req,
	output logic [1:0] state_out
);
	// ****************************************
	// parameter check
	// ****************************************
	if (N_START < 1 || N_START > 13) begin : g_bad_n
		$error("start pin count out of range");
	end

	// ****************************************
	// register bus decode
	// ****************************************
	logic [5:0] mode_ff;
	logic [5:0] nxt_mode;
	logic [N_START-1:0] enable_ff;
	logic [N_START-1:0] nxt_enable;
	logic [N_START-1:0] flag_ff;
	logic [N_START-1:0] nxt_flag;
	logic [N_START-1:0] pin_d_ff;
	lpm_pkg::pwr_state_t state_ff;
	lpm_pkg::pwr_state_t nxt_state;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic [31:0] rd_mux;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_mode = paddr == lpm_pkg::A_MODE;
	wire hit_en = paddr == lpm_pkg::A_ENABLE;
	wire hit_stat = paddr == lpm_pkg::A_STATUS;
	wire hit_flag = paddr == lpm_pkg::A_START_FLAG;
	wire hit_any = hit_mode | hit_en | hit_stat | hit_flag;
	wire [N_START-1:0] flag_clr = (wr & hit_flag) ? pwdata[N_START-1:0] : '0;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit_any;
	assign rd_mux = hit_mode ? {26'h000_0000, mode_ff} :
		hit_en ? 32'(enable_ff) :
		hit_stat ? {30'h0000_0000, state_ff} :
		hit_flag ? 32'(flag_ff) : 32'h0000_0000;
	assign nxt_prdata = (psel & ~penable & ~pwrite) ? rd_mux : prdata_ff;
	assign prdata = prdata_ff;
	assign nxt_mode = (wr & hit_mode) ? pwdata[5:0] : mode_ff;
	assign nxt_enable = (wr & hit_en) ? pwdata[N_START-1:0] : enable_ff;

	// ****************************************
	// start logic
	// ****************************************
	// falling-edge capture: a pin sets its flag only when high on the previous pclk edge (or loaded high by reset) and low now
	wire [N_START-1:0] pin_fall;
	genvar gi;
	for (gi = 0; gi < N_START; gi++) begin : g_start
		assign pin_fall[gi] = pin_d_ff[gi] & ~start_pin[gi];
		assign nxt_flag[gi] = pin_fall[gi] | (flag_ff[gi] & ~flag_clr[gi]);
		assign start_irq[gi] = flag_ff[gi] & enable_ff[gi];
		a_pin_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
			pin_fall[gi] && enable_ff[gi] && !(wr && hit_en) |=> start_irq[gi])
			else $error("start interrupt missing");
		a_pin_deep_wake: assert property (@(posedge pclk) disable iff (!presetn)
			state_ff == lpm_pkg::ST_DEEP && !start_pin[gi] && enable_ff[gi]
			|=> state_ff == lpm_pkg::ST_RUN)
			else $error("start pin wake missed");
	end

	// level wake path is combinational from pins, so it skips the edge flags; the state change still waits for a pclk edge
	wire start_wake = |(~start_pin & enable_ff);

	// ****************************************
	// mode state machine
	// ****************************************
	wire [1:0] sel = mode_ff[1:0];
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			lpm_pkg::ST_RUN: begin
				if (sleep_req) begin
					if (sel == lpm_pkg::SEL_DPD) nxt_state = lpm_pkg::ST_DPD;
					else if (sel == lpm_pkg::SEL_DEEP) nxt_state = lpm_pkg::ST_DEEP;
					else nxt_state = lpm_pkg::ST_SLEEP;
				end
			end
			lpm_pkg::ST_SLEEP: begin
				if (periph_irq | (|start_irq)) nxt_state = lpm_pkg::ST_RUN;
			end
			lpm_pkg::ST_DEEP: begin
				if (start_wake) nxt_state = lpm_pkg::ST_RUN;
			end
			lpm_pkg::ST_DPD: begin
				if (!wake_pin_n) nxt_state = lpm_pkg::ST_RUN;
			end
			default: nxt_state = lpm_pkg::ST_RUN;
		endcase
	end
	wire in_dpd = state_ff == lpm_pkg::ST_DPD;
	wire in_deep = state_ff == lpm_pkg::ST_DEEP;
	assign pwr_ctl.core_clk_en = state_ff == lpm_pkg::ST_RUN;
	assign pwr_ctl.analog_en = ~(in_deep | in_dpd);
	wire keep_wdosc = mode_ff[lpm_pkg::B_KEEP_WDOSC];
	wire keep_brownout = mode_ff[lpm_pkg::B_KEEP_BROWNOUT];
	assign pwr_ctl.wdosc_en = ~in_dpd & (~in_deep | keep_wdosc);
	assign pwr_ctl.brownout_en = ~in_dpd & (~in_deep | keep_brownout);
	assign pwr_ctl.chip_power_en = ~in_dpd;
	// waking from power-down restarts the chip
	assign core_reset_req = in_dpd & ~wake_pin_n;
	assign state_out = state_ff;

	// ****************************************
	// registers
	// ****************************************
	// reset has no effect while powered down: only the wake pin exits
	wire eff_rst_n = presetn | in_dpd;
	always_ff @(posedge pclk or negedge eff_rst_n) begin
		if (!eff_rst_n) begin
			state_ff <= lpm_pkg::ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end
	always_ff @(posedge pclk or negedge eff_rst_n) begin
		if (!eff_rst_n) begin
			mode_ff <= {4'h0, lpm_pkg::MODE_RST};
		end else begin
			mode_ff <= nxt_mode;
		end
	end
	always_ff @(posedge pclk or negedge eff_rst_n) begin
		if (!eff_rst_n) begin
			enable_ff <= '0;
		end else begin
			enable_ff <= nxt_enable;
		end
	end
	always_ff @(posedge pclk or negedge eff_rst_n) begin
		if (!eff_rst_n) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end
	always_ff @(posedge pclk or negedge eff_rst_n) begin
		if (!eff_rst_n) begin
			pin_d_ff <= '1;
		end else begin
			pin_d_ff <= start_pin;
		end
	end
	always_ff @(posedge pclk or negedge eff_rst_n) begin
		if (!eff_rst_n) begin
			prdata_ff <= 32'h0000_0000;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	a_sleep_clk_gate: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_SLEEP |-> !pwr_ctl.core_clk_en && pwr_ctl.analog_en)
		else $error("core clock not gated in sleep");
	a_sleep_exit_irq: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_SLEEP && periph_irq |=> state_ff == lpm_pkg::ST_RUN)
		else $error("sleep not left on interrupt");
	a_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_SLEEP && !periph_irq && start_irq == '0
		|=> state_ff == lpm_pkg::ST_SLEEP)
		else $error("sleep left without cause");
	a_deep_analog: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP |-> !pwr_ctl.analog_en && !pwr_ctl.core_clk_en)
		else $error("analog on in deep-sleep");
	a_deep_wdosc: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP |-> pwr_ctl.wdosc_en == mode_ff[lpm_pkg::B_KEEP_WDOSC])
		else $error("watchdog oscillator option ignored");
	a_deep_wake: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP && start_wake |=> state_ff == lpm_pkg::ST_RUN)
		else $error("start pin did not wake");
	a_dpd_power: assert property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD |-> !pwr_ctl.chip_power_en)
		else $error("power on in power-down");
	a_dpd_wake: assert property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD && !wake_pin_n |=> state_ff == lpm_pkg::ST_RUN)
		else $error("wake pin ignored");
	a_dpd_no_reset: assert property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD && wake_pin_n |=> state_ff == lpm_pkg::ST_DPD)
		else $error("power-down left without wake pin");
	a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		|pin_fall |=> (flag_ff & $past(pin_fall)) == $past(pin_fall))
		else $error("start flag lost");
	a_mode_entry: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_RUN && sleep_req && mode_ff[1:0] == lpm_pkg::SEL_DEEP
		|=> state_ff == lpm_pkg::ST_DEEP)
		else $error("selected mode not entered");
	a_mode_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_RUN && sleep_req && sel == lpm_pkg::SEL_SLEEP
		|=> state_ff == lpm_pkg::ST_SLEEP)
		else $error("sleep not entered");
	a_mode_dpd: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_RUN && sleep_req && sel == lpm_pkg::SEL_DPD
		|=> state_ff == lpm_pkg::ST_DPD)
		else $error("power-down not entered");
	a_mode_spare: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_RUN && sleep_req && sel == 2'h3
		|=> state_ff == lpm_pkg::ST_SLEEP)
		else $error("spare mode not sleep");
	a_run_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_RUN && !sleep_req |=> state_ff == lpm_pkg::ST_RUN)
		else $error("run left without request");
	a_sleep_start_wake: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_SLEEP && start_irq != '0 |=> state_ff == lpm_pkg::ST_RUN)
		else $error("sleep not left on start interrupt");
	a_deep_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP && !start_wake |=> state_ff == lpm_pkg::ST_DEEP)
		else $error("deep-sleep left without cause");

	// ****************************************
	// power output checks
	// ****************************************
	a_run_all_on: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_RUN |-> pwr_ctl == '1)
		else $error("supply off while running");
	a_sleep_others_on: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_SLEEP |-> pwr_ctl.wdosc_en && pwr_ctl.brownout_en)
		else $error("other clocks touched in sleep");
	a_deep_bod: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP |-> pwr_ctl.brownout_en == keep_brownout)
		else $error("brownout option ignored");
	a_deep_power: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP |-> pwr_ctl.chip_power_en)
		else $error("chip power off in deep-sleep");
	a_dpd_all_off: assert property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD |-> !pwr_ctl.analog_en && !pwr_ctl.wdosc_en
		&& !pwr_ctl.brownout_en && !pwr_ctl.core_clk_en)
		else $error("block powered in power-down");
	a_dpd_reset_req: assert property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD && !wake_pin_n |-> core_reset_req)
		else $error("no restart on wake");
	a_no_reset_req: assert property (@(posedge pclk)
		state_ff != lpm_pkg::ST_DPD |-> !core_reset_req)
		else $error("restart outside power-down");

	// ****************************************
	// register bus checks
	// ****************************************
	a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_flag && pin_fall == '0 |=> (flag_ff & $past(pwdata[N_START-1:0])) == '0)
		else $error("start flag not cleared");
	a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && hit_flag) |=> (flag_ff & $past(flag_ff)) == $past(flag_ff))
		else $error("start flag lost without clear");
	a_wr_mode: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_mode |=> mode_ff == $past(pwdata[5:0]))
		else $error("mode write lost");
	a_wr_enable: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_en |=> enable_ff == $past(pwdata[N_START-1:0]))
		else $error("enable write lost");
	a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && hit_stat |=> prdata[1:0] == $past(state_ff))
		else $error("status read wrong");
	a_rd_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && !hit_any |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		acc && hit_any |-> !pslverr)
		else $error("error on mapped register");
	c_sleep_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_SLEEP ##[1:20] state_ff == lpm_pkg::ST_RUN);
	c_deep_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP ##[1:20] state_ff == lpm_pkg::ST_RUN);
	c_dpd_cycle: cover property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD ##[1:20] state_ff == lpm_pkg::ST_RUN);
	c_deep_irq: cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == lpm_pkg::ST_DEEP ##1 start_irq != '0);
	c_dpd_reset_low: cover property (@(posedge pclk)
		state_ff == lpm_pkg::ST_DPD && !presetn);
endmodule // low_power_mode_control
`default_nettype wire

// File: rtl/_end.sv
// empty

// File: testbench/core_pins_model.sv
// core and wake-pin model on the far side of the controller
`default_nettype none
module core_pins_model (
	input wire logic pclk,
	input wire logic go_sleep,
	input wire logic irq,
	input wire logic [12:0] pin_low,
	input wire logic wake,
	output logic sleep_req,
	output logic periph_irq,
	output logic [12:0] start_pin,
	output logic wake_pin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sleep_req = 1'b0;
		periph_irq = 1'b0;
		start_pin = 13'h1fff;
		wake_pin_n = 1'b1;
	end
	// pins idle at pull-up level; wake low held whole cycles
	always @(posedge pclk) begin
		sleep_req <= go_sleep;
		periph_irq <= irq;
		start_pin <= ~pin_low;
		wake_pin_n <= ~wake;
	end
endmodule // core_pins_model
`default_nettype wire

// File: testbench/test_low_power_mode_control.sv
// self-checking bench for the low-power mode controller
`default_nettype none
`define chk(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_low_power_mode_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, sleep_req, periph_irq, wake_pin_n, core_reset_req;
	logic go_sleep = 1'b0, irq = 1'b0, wake = 1'b0;
	logic [12:0] pin_low = 13'h0000, start_pin, start_irq;
	logic [1:0] state_out;
	lpm_pkg::pwr_ctl_t pwr_ctl;
	int num_errors = 0, n_checks = 0;
	typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} row_t;
	row_t rows[7] = '{
		'{lpm_pkg::A_MODE, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{lpm_pkg::A_ENABLE, 1'b1, 32'h0000_1fff, 32'h0000_0000, 1'b0},
		'{lpm_pkg::A_ENABLE, 1'b0, 32'h0000_0000, 32'h0000_1fff, 1'b0},
		// watchdog oscillator kept, so no clock switch before deep-sleep
		'{lpm_pkg::A_MODE, 1'b1, 32'h0000_0031, 32'h0000_0000, 1'b0},
		'{lpm_pkg::A_MODE, 1'b0, 32'h0000_0000, 32'h0000_0031, 1'b0},
		'{lpm_pkg::A_STATUS, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{12'h010, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1}};
	low_power_mode_control low_power_mode_control_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
		.periph_irq(periph_irq), .start_pin(start_pin), .wake_pin_n(wake_pin_n),
		.start_irq(start_irq), .pwr_ctl(pwr_ctl), .core_reset_req(core_reset_req),
		.state_out(state_out));
	core_pins_model core_pins_model_i (.pclk(pclk), .go_sleep(go_sleep), .irq(irq),
		.pin_low(pin_low), .wake(wake), .sleep_req(sleep_req), .periph_irq(periph_irq),
		.start_pin(start_pin), .wake_pin_n(wake_pin_n));
	always #50 pclk = ~pclk;
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_state(input logic [1:0] s);
		int k;
		k = 0;
		while (state_out !== s && k < 20) begin
			@(posedge pclk);
			#1;
			k++;
		end
	endtask
	task automatic pulse_sleep();
		@(posedge pclk);
		go_sleep <= 1'b1;
		@(posedge pclk);
		go_sleep <= 1'b0;
	endtask
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		`chk(pwr_ctl, 5'b11111)
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			`chk(err, rows[i].e)
			if (!rows[i].w) `chk(rd, rows[i].q)
		end
		// deep-sleep with both keep options, woken by start pin 12
		pulse_sleep();
		wait_state(2'h2);
		`chk(pwr_ctl, 5'b00111)
		@(posedge pclk);
		pin_low <= 13'h1000;
		wait_state(2'h0);
		`chk(state_out, 2'h0)
		`chk(start_irq, 13'h1000)
		@(posedge pclk);
		pin_low <= 13'h0000;
		apb(lpm_pkg::A_START_FLAG, 1'b0, 32'h0000_0000);
		`chk(rd, 32'h0000_1000)
		apb(lpm_pkg::A_START_FLAG, 1'b1, 32'h0000_1000);
		#1;
		`chk(start_irq, 13'h0000)
		// sleep, woken by peripheral interrupt
		apb(lpm_pkg::A_MODE, 1'b1, 32'h0000_0000);
		pulse_sleep();
		wait_state(2'h1);
		`chk(pwr_ctl, 5'b01111)
		@(posedge pclk);
		irq <= 1'b1;
		wait_state(2'h0);
		`chk(pwr_ctl, 5'b11111)
		@(posedge pclk);
		irq <= 1'b0;
		// power-down, reset ignored, wake pin exits
		apb(lpm_pkg::A_MODE, 1'b1, 32'h0000_0002);
		pulse_sleep();
		wait_state(2'h3);
		`chk(pwr_ctl.chip_power_en, 1'b0)
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`chk(state_out, 2'h3)
		presetn <= 1'b1;
		wake <= 1'b1;
		@(posedge pclk);
		#1;
		`chk(core_reset_req, 1'b1)
		wait_state(2'h0);
		`chk(state_out, 2'h0)
		tally_and_finish();
	end
endmodule // test_low_power_mode_control
`default_nettype wire
